// [inc/dcr_pkg.sv]
package dcr_pkg;

   // Core clock period and analog minimums in picoseconds
   localparam int CLK_PS  = 25000;
   localparam int TRTP_PS = 7500;
   localparam int TRAS_PS = 35000;

   // Least times round up to whole cycles
   localparam logic [3:0] TRTP_CYC = 4'((TRTP_PS + CLK_PS - 1) / CLK_PS);
   localparam logic [5:0] TRAS_CYC = 6'((TRAS_PS + CLK_PS - 1) / CLK_PS);

   localparam logic [4:0] CL_RST = 5'h06;
   localparam logic [4:0] AL_RST = 5'h00;

   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CFG  = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_MR0  = 8'h10;
   localparam logic [7:0] REG_MR1  = 8'h14;
   localparam logic [7:0] REG_MR2  = 8'h18;
   localparam logic [7:0] REG_MR3  = 8'h1c;

   // Configuration register field positions
   localparam int CFG_CL_LSB   = 0;
   localparam int CFG_AL_LSB   = 8;
   localparam int CFG_TRTP_LSB = 16;
   localparam int CFG_TRAS_LSB = 24;

   // Status register field positions
   localparam int STAT_CAL_BIT  = 8;
   localparam int STAT_BUSY_BIT = 9;

   localparam logic [13:0] MR_RST = 14'h0000;

   // Address bit roles on commands
   localparam int NIB_BIT = 2;
   localparam int AP_BIT  = 10;
   localparam int BC_BIT  = 12;
   localparam int CAL_EN_BIT = 2;

   // Burst lengths in command clocks, and nibble base beat
   localparam logic [2:0] BL8_CYC  = 3'h4;
   localparam logic [2:0] BC4_CYC  = 3'h2;
   localparam logic [2:0] UPPER_BEAT = 3'h4;
   localparam logic [3:0] PRE_MIN_CYC = 4'h4;

   // Calibration pattern, beat 0 in the LSB
   localparam logic [7:0] CAL_PATTERN = 8'haa;

   typedef enum logic [2:0] {
      DCR_MRS = 3'b000,
      DCR_REF = 3'b001,
      DCR_PRE = 3'b010,
      DCR_ACT = 3'b011,
      DCR_WR  = 3'b100,
      DCR_RD  = 3'b101,
      DCR_ZQ  = 3'b110,
      DCR_NOP = 3'b111
   } dcr_cmd_t;

endpackage

// [inc/dcr_rd_if.sv]
`timescale 1ns/100ps
interface dcr_rd_if #(parameter int DW = 8);
   logic              launch;
   logic              bc4;
   logic              upper;
   logic              cal;
   logic [5:0]        rl;
   logic [2*DW-1:0]   arr_data;
   logic              busy;

   modport src  (output launch, bc4, upper, cal, rl, arr_data, input busy);
   modport sink (input launch, bc4, upper, cal, rl, arr_data, output busy);
endinterface

// [src/dcr_burst.sv]
`timescale 1ns/100ps
module dcr_burst #(
   parameter int DW     = 8,
   parameter int MAX_RL = 32
) (
   input  wire logic            core_clk,
   input  wire logic            arst_n,
   dcr_rd_if.sink               rd,
   output logic [2*DW-1:0]      dq_o,
   output logic                 dq_oe,
   output logic [1:0]           dqs_o,
   output logic                 dqs_oe
);

   // Entry: {valid, bc4, upper, cal}; entry 0 launches next clock
   logic [3:0]  ent [MAX_RL];
   logic [2:0]  cnt;
   logic [2:0]  beat;
   logic        cal;
   logic [2:0]  next_beat;
   logic        start;
   logic        more;
   logic        next_oe;
   logic        next_cal;
   logic [MAX_RL-1:0] vmask;

   genvar i;
   generate
      for (i = 0; i < MAX_RL; i++) begin : g_ent
         wire ins = rd.launch && (rd.rl == 6'(i + 1));
         wire [3:0] fill = {1'b1, rd.bc4, rd.upper, rd.cal};
         assign vmask[i] = ent[i][3];
         if (i == MAX_RL - 1) begin : g_last
            always_ff @(posedge core_clk or negedge arst_n) begin
               if (!arst_n) ent[i] <= 4'h0;
               else         ent[i] <= ins ? fill : 4'h0;
            end
         end else begin : g_mid
            always_ff @(posedge core_clk or negedge arst_n) begin
               if (!arst_n) ent[i] <= 4'h0;
               else         ent[i] <= ins ? fill : ent[i+1];
            end
         end
      end
   endgenerate

   assign start     = ent[0][3];
   assign more      = cnt > 3'h1;
   assign next_oe   = start || more;
   assign next_cal  = start ? ent[0][0] : cal;
   assign next_beat = start ? (ent[0][1] ? dcr_pkg::UPPER_BEAT : 3'h0)
                            : 3'(beat + 3'h2);
   assign rd.busy   = (|vmask) || (cnt != 3'h0);

   wire pat_rise = dcr_pkg::CAL_PATTERN[next_beat];
   wire pat_fall = dcr_pkg::CAL_PATTERN[3'(next_beat + 3'h1)];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= 3'h0;
         beat <= 3'h0;
         cal  <= 1'b0;
      end else if (start) begin
         cnt  <= ent[0][2] ? dcr_pkg::BC4_CYC : dcr_pkg::BL8_CYC;
         beat <= next_beat;
         cal  <= next_cal;
      end else if (cnt != 3'h0) begin
         cnt  <= 3'(cnt - 3'h1);
         beat <= next_beat;
      end
   end

   // Two beats per clock: low half rising edge, high half falling edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_o   <= '0;
         dq_oe  <= 1'b0;
         dqs_o  <= 2'b00;
         dqs_oe <= 1'b0;
      end else begin
         dq_oe  <= next_oe;
         dq_o   <= !next_oe ? '0
                 : next_cal ? {{DW{pat_fall}}, {DW{pat_rise}}}
                 : rd.arr_data;
         // Strobe is low in the rising half and high in the last half beat, which forms the postamble
         dqs_o  <= next_oe ? 2'b10 : 2'b00;
         dqs_oe <= next_oe || ent[1][3];
      end
   end

   property p_cal_data;
      @(posedge core_clk) disable iff (!arst_n)
      (dq_oe && cal) |-> dq_o == {{DW{1'b1}}, {DW{1'b0}}};
   endproperty
   a_cal_data: assert property (p_cal_data)
      else $error("calibration beat pair is not 0 then 1");

   property p_preamble;
      @(posedge core_clk) disable iff (!arst_n)
      $rose(dq_oe) |-> $past(dqs_oe) && ($past(dqs_o) == 2'b00);
   endproperty
   a_preamble: assert property (p_preamble)
      else $error("read data started without a strobe preamble");

   property p_postamble;
      @(posedge core_clk) disable iff (!arst_n)
      $fell(dq_oe) |-> !dqs_oe && ($past(dqs_o) == 2'b10);
   endproperty
   a_postamble: assert property (p_postamble)
      else $error("strobe not released low after the last beat");

   property p_bl8_len;
      @(posedge core_clk) disable iff (!arst_n)
      // A follow-on start at the fourth clock keeps the data running
      (start && !ent[0][2] && !more) |=> dq_oe [*4] ##1
      (dq_oe == $past(start));
   endproperty
   a_bl8_len: assert property (p_bl8_len)
      else $error("eight-beat burst did not last four clocks");

   property p_nibble;
      @(posedge core_clk) disable iff (!arst_n)
      (start && ent[0][1]) |=> beat == 3'h4 ##1 beat == 3'h6;
   endproperty
   a_nibble: assert property (p_nibble)
      else $error("upper nibble chop did not begin at beat four");

endmodule

// [src/dcr_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - Calibration mode reads return 0,1,0,1,0,1,0,1 instead of array data.
// - Writing register three with 100 enables pattern reads after settling.
// - Bank address 000..011 picks mode register zero..three, value from A.
// - First read data appears AL plus CL clocks after the read.
// - Strobe preamble before data, postamble with last beat, then float.
// - A read start mid-burst cuts the running burst short; eight-beat reads tCCD apart run seamlessly.
// - Auto precharge at AL plus tRTP (at least four clocks), held off until tRAS.
// - Chopped calibration read: A2 selects lower or upper nibble.
module dcr_top #(
   parameter int DW     = 8,
   parameter int MAX_RL = 32,
   parameter int BANKS  = 8
) (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic [2:0]        ba,
   input  wire logic [13:0]       addr,
   input  wire logic [2*DW-1:0]   arr_data,
   output logic      [2*DW-1:0]   dq_o,
   output logic                   dq_oe,
   output logic      [1:0]        dqs_o,
   output logic      [1:0]        dqs_n_o,
   output logic                   dqs_oe,
   output logic      [BANKS-1:0]  bank_open,
   output logic      [BANKS-1:0]  bank_autopre,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata
);

   dcr_pkg::dcr_cmd_t cmd;
   logic [13:0]  mr [4];
   logic [4:0]   cl;
   logic [4:0]   al;
   logic [3:0]   trtp;
   logic [5:0]   tras;
   logic [31:0]  next_rdata;

   dcr_rd_if #(.DW(DW)) rd_bus ();

   // Command decode
   assign cmd = dcr_pkg::dcr_cmd_t'({ras_n, cas_n, we_n});
   wire is_mrs = !cs_n && (cmd == dcr_pkg::DCR_MRS);
   wire is_act = !cs_n && (cmd == dcr_pkg::DCR_ACT);
   wire is_pre = !cs_n && (cmd == dcr_pkg::DCR_PRE);
   wire is_rd  = !cs_n && (cmd == dcr_pkg::DCR_RD);

   // Pattern source selected only by enable bit with mode field 00
   wire cal_mode = mr[3][dcr_pkg::CAL_EN_BIT] && (mr[3][1:0] == 2'b00);

   wire [5:0] rl = 6'({1'b0, al} + {1'b0, cl});
   wire [3:0] rtp_eff = (trtp > dcr_pkg::PRE_MIN_CYC) ? trtp
                                                      : dcr_pkg::PRE_MIN_CYC;
   wire [5:0] ap_wait = 6'({1'b0, al} + {2'b00, rtp_eff});

   // Read launch toward the burst engine
   assign rd_bus.launch   = is_rd;
   assign rd_bus.bc4      = !addr[dcr_pkg::BC_BIT];
   assign rd_bus.upper    = !addr[dcr_pkg::BC_BIT] && addr[dcr_pkg::NIB_BIT];
   assign rd_bus.cal      = cal_mode;
   assign rd_bus.rl       = rl;
   assign rd_bus.arr_data = arr_data;

   dcr_burst #(.DW(DW), .MAX_RL(MAX_RL)) u_burst (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .rd       (rd_bus),
      .dq_o     (dq_o),
      .dq_oe    (dq_oe),
      .dqs_o    (dqs_o),
      .dqs_oe   (dqs_oe)
   );

   assign dqs_n_o = ~dqs_o;

   // Mode registers
   genvar m;
   generate
      for (m = 0; m < 4; m++) begin : g_mr
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               mr[m] <= dcr_pkg::MR_RST;
            end else if (is_mrs && (ba == 3'(m))) begin
               mr[m] <= addr;
            end
         end
      end
   endgenerate

   // Per-bank row state and auto precharge timing
   genvar b;
   generate
      for (b = 0; b < BANKS; b++) begin : g_bank
         logic [5:0] ras_cnt;
         logic [5:0] ap_cnt;
         logic       ap_pend;
         wire hit    = (ba == 3'(b));
         wire ras_ok = ras_cnt >= tras;
         // tRAS lockout holds the countdown at one until the row is old enough
         wire fire   = ap_pend && (ap_cnt == 6'h01) && ras_ok;
         wire close  = is_pre && (hit || addr[dcr_pkg::AP_BIT]);

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               ras_cnt <= 6'h00;
            end else if (is_act && hit) begin
               ras_cnt <= 6'h01;
            end else if (ras_cnt != 6'h3f) begin
               ras_cnt <= 6'(ras_cnt + 6'h01);
            end
         end

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               ap_pend <= 1'b0;
               ap_cnt  <= 6'h00;
            end else if (is_rd && hit && addr[dcr_pkg::AP_BIT]) begin
               ap_pend <= 1'b1;
               ap_cnt  <= ap_wait;
            end else if (fire || close) begin
               ap_pend <= 1'b0;
            end else if (ap_pend && (ap_cnt > 6'h01)) begin
               ap_cnt  <= 6'(ap_cnt - 6'h01);
            end
         end

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               bank_open[b]    <= 1'b0;
               bank_autopre[b] <= 1'b0;
            end else begin
               bank_autopre[b] <= fire;
               if (is_act && hit) begin
                  bank_open[b] <= 1'b1;
               end else if (fire || close) begin
                  bank_open[b] <= 1'b0;
               end
            end
         end

         property p_autopre;
            @(posedge core_clk) disable iff (!arst_n)
            (is_rd && hit && addr[dcr_pkg::AP_BIT] && (al == 5'h00)
             && (trtp <= 4'h4) && ras_ok) |-> ##4 fire;
         endproperty
         a_autopre: assert property (p_autopre)
            else $error("auto precharge not started four clocks after read");
      end
   endgenerate

   // Register port
   wire sel_cfg = reg_addr == dcr_pkg::REG_CFG;
   wire [31:0] cfg_word = {2'b00, tras, 4'h0, trtp, 3'h0, al, 3'h0, cl};
   wire [31:0] stat_word = {22'h000000, rd_bus.busy, cal_mode, bank_open};

   always_comb begin
      unique case (reg_addr)
         dcr_pkg::REG_CFG:  next_rdata = cfg_word;
         dcr_pkg::REG_STAT: next_rdata = stat_word;
         dcr_pkg::REG_MR0:  next_rdata = {18'h00000, mr[0]};
         dcr_pkg::REG_MR1:  next_rdata = {18'h00000, mr[1]};
         dcr_pkg::REG_MR2:  next_rdata = {18'h00000, mr[2]};
         dcr_pkg::REG_MR3:  next_rdata = {18'h00000, mr[3]};
         default:           next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) reg_rdata <= 32'h00000000;
      else         reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cl   <= dcr_pkg::CL_RST;
         al   <= dcr_pkg::AL_RST;
         trtp <= dcr_pkg::TRTP_CYC;
         tras <= dcr_pkg::TRAS_CYC;
      end else if (reg_wr && sel_cfg) begin
         cl   <= reg_wdata[dcr_pkg::CFG_CL_LSB +: 5];
         al   <= reg_wdata[dcr_pkg::CFG_AL_LSB +: 5];
         trtp <= reg_wdata[dcr_pkg::CFG_TRTP_LSB +: 4];
         tras <= reg_wdata[dcr_pkg::CFG_TRAS_LSB +: 6];
      end
   end

   property p_mrs_sel;
      @(posedge core_clk) disable iff (!arst_n)
      (is_mrs && (ba == 3'b001)) |=> (mr[1] == $past(addr))
                                     && $stable(mr[0]);
   endproperty
   a_mrs_sel: assert property (p_mrs_sel)
      else $error("mode register set hit the wrong register");

   property p_cal_enter;
      @(posedge core_clk) disable iff (!arst_n)
      (is_mrs && (ba == 3'b011) && (addr[2:0] == 3'b100)) |=> cal_mode;
   endproperty
   a_cal_enter: assert property (p_cal_enter)
      else $error("calibration mode not entered after register write");

   property p_read_lat;
      @(posedge core_clk) disable iff (!arst_n)
      // Output register: data of cycle RL is seen at the edge after it
      (is_rd && (rl == 6'h05) && !rd_bus.busy) |-> ##6 $rose(dq_oe);
   endproperty
   a_read_lat: assert property (p_read_lat)
      else $error("first read data not at read latency");

endmodule

// [verification/dcr_ctrl_model.sv]
`timescale 1ns/100ps
module dcr_ctrl_model (
   input  wire logic        core_clk,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [2:0]       ba,
   output logic [13:0]      addr
);
   initial begin
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'b111;
      ba = 3'h0;
      addr = 14'h0000;
   end

   // One command clock, then deselect; caller's gap keeps spacing
   // Only reads and mode register sets issued while pattern source is on
   // Never writes or calibrates impedance
   task automatic issue(input dcr_pkg::dcr_cmd_t op, input logic [2:0] b,
                        input logic [13:0] a, input int gap);
      @(posedge core_clk);
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= op;
      ba <= b;
      addr <= a;
      @(posedge core_clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'b111;
      // Deselected lines must not keep the last value
      ba <= ~b;
      addr <= ~a;
      repeat (gap - 2) @(posedge core_clk);
   endtask
endmodule

// [verification/ddr3_calib_activate_read_rules_tb_top.sv]
`timescale 1ns/100ps
module ddr3_calib_activate_read_rules_tb_top;
   localparam logic [13:0] RD_A [5] = '{14'h1000, 14'h1008, 14'h0010,
                                        14'h0014, 14'h1000};
   localparam int          RD_G [5] = '{4, 4, 4, 12, 4};
   logic              core_clk;
   logic              arst_n;
   logic              cs_n, ras_n, cas_n, we_n;
   logic [2:0]        ba;
   logic [13:0]       addr;
   logic [15:0]       arr_data;
   logic [15:0]       dq_o;
   logic              dq_oe;
   logic [1:0]        dqs_o;
   logic [1:0]        dqs_n_o;
   logic              dqs_oe;
   logic [7:0]        bank_open;
   logic [7:0]        bank_autopre;
   logic [7:0]        reg_addr;
   logic [31:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [31:0]       reg_rdata;
   int                n_errors, n_compared, cyc, st, rl, al, trtp, tras, ta;
   int                exp_st [64] = '{default: 0};
   int                act_cyc [8] = '{default: 0};
   logic [7:0]        exp_ap [64] = '{default: 8'h00};
   logic [7:0]        exp_open = 8'h00;
   logic [31:0]       seed_d = 32'h5b5b9fcb;
   logic [31:0]       seed_m = 32'h5b5b9fcb;
   logic [15:0]       prev_arr;
   logic [13:0]       v;
   bit                cal;

   dcr_ctrl_model ctrl (.core_clk, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
   dcr_top DUT (.core_clk, .arst_n, .cs_n, .ras_n, .cas_n, .we_n, .ba,
      .addr, .arr_data, .dq_o, .dq_oe, .dqs_o, .dqs_n_o, .dqs_oe,
      .bank_open, .bank_autopre, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata);

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      seed_d <= xs(seed_d);
      arr_data <= seed_d[15:0];
   end

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         cyc <= 0;
      else
         cyc <= cyc + 1;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] e,
                      input string what);
      n_compared++;
      if (got !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, e);
      end
   endtask

   // Reference model of one command seen on the pins before its edge
   task automatic model_cmd();
      int n;
      int c;
      // Seen half a clock early; taken at the next rising edge
      c = cyc + 1;
      case ({ras_n, cas_n, we_n})
         3'b000: if (ba == 3'h3) cal = addr[2:0] == 3'b100;
         3'b011: begin
            act_cyc[ba] = c;
            exp_open[ba] = 1'b1;
         end
         3'b010: exp_open = addr[10] ? 8'h00 : exp_open & ~(8'h01 << ba);
         3'b101: begin
            n = addr[12] ? 4 : 2;
            if (exp_st[(c + rl - 1) % 64] == 0)
               exp_st[(c + rl - 1) % 64] = 1;
            for (int k = 0; k < n; k++)
               exp_st[(c + rl + k) % 64] = cal ? 3 : 2;
            if (addr[10]) begin
               ta = c + al + (trtp > 4 ? trtp : 4);
               if (ta < act_cyc[ba] + tras)
                  ta = act_cyc[ba] + tras;
               exp_ap[ta % 64][ba] = 1'b1;
            end
         end
         default: ;
      endcase
   endtask

   always @(negedge core_clk) begin
      if (arst_n) begin
         st = exp_st[cyc % 64];
         exp_st[cyc % 64] = 0;
         cmp(dqs_oe, st != 0, "strobe enable");
         cmp(dq_oe, st > 1, "data enable");
         cmp(dqs_n_o, 2'(~dqs_o), "strobe complement");
         if (st == 1)
            cmp(dqs_o, 2'b00, "preamble");
         if (st > 1)
            cmp({dqs_o, dq_o}, {2'b10, st == 3 ? 16'hff00 : prev_arr},
                "beat");
         cmp(bank_autopre, exp_ap[cyc % 64], "auto precharge");
         exp_open &= ~exp_ap[cyc % 64];
         exp_ap[cyc % 64] = 8'h00;
         if (!cs_n)
            model_cmd();
      end
      prev_arr = arr_data;
   end

   task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      cmp(reg_rdata, e, "register read");
      @(negedge core_clk);
      cmp(reg_rdata, 32'h0, "read data release");
   endtask

   // Timing fields in whole cycles, minimums already rounded up
   task automatic cfg(input int c, input int a, input int p, input int r);
      logic [31:0] w;
      w = {2'b00, 6'(r), 4'h0, 4'(p), 3'b000, 5'(a), 3'b000, 5'(c)};
      reg_wr_t(dcr_pkg::REG_CFG, w);
      reg_chk(dcr_pkg::REG_CFG, w);
      rl = c + a;
      al = a;
      trtp = p;
      tras = r;
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(25 * 4000);
      n_errors++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      arst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rl = 6;
      al = 0;
      trtp = 1;
      tras = 2;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      cmp({dqs_n_o, dq_oe, dqs_oe, bank_open}, {2'b11, 10'h0}, "reset");
      @(posedge core_clk);
      arst_n <= 1'b1;
      reg_chk(dcr_pkg::REG_CFG, 32'h0201_0006);
      reg_chk(8'h08, 32'h0);
      reg_wr_t(dcr_pkg::REG_MR0, 32'h3fff);
      reg_chk(dcr_pkg::REG_MR0, 32'h0);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         seed_m = xs(seed_m);
         // Register three stays in array mode here
         v = seed_m[13:0] & (i == 3 ? 14'h3ffb : 14'h3fff);
         ctrl.issue(dcr_pkg::DCR_MRS, 3'(i), v, 4);
         reg_chk(dcr_pkg::REG_MR0 + 8'(4 * i), {18'h0, v});
      end
      $display("test mode register select done");
      for (int j = 0; j < 2; j++) begin
         cfg(5 + j, 3 * j, 1, 2);
         ctrl.issue(dcr_pkg::DCR_ACT, 3'h1, 14'h0123, 4);
         for (int k = 0; k < 5; k++)
            ctrl.issue(dcr_pkg::DCR_RD, 3'h1, RD_A[k], RD_G[k]);
         repeat (16) @(posedge core_clk);
         reg_chk(dcr_pkg::REG_STAT, 32'h0000_0002);
         ctrl.issue(dcr_pkg::DCR_PRE, 3'h0, 14'h0400, 4);
         cmp(bank_open, exp_open, "banks closed");
      end
      $display("test read bursts done");
      // Long row lockout, then read-to-precharge bound by tRTP
      cfg(5, 0, 1, 20);
      ctrl.issue(dcr_pkg::DCR_ACT, 3'h2, 14'h0040, 2);
      ctrl.issue(dcr_pkg::DCR_RD, 3'h2, 14'h1400, 30);
      cfg(5, 0, 6, 2);
      ctrl.issue(dcr_pkg::DCR_ACT, 3'h4, 14'h0040, 4);
      ctrl.issue(dcr_pkg::DCR_RD, 3'h4, 14'h1400, 20);
      // Short read-to-precharge clamped to four clocks, row old enough
      cfg(5, 0, 1, 2);
      ctrl.issue(dcr_pkg::DCR_ACT, 3'h6, 14'h0040, 4);
      ctrl.issue(dcr_pkg::DCR_RD, 3'h6, 14'h1400, 12);
      cmp(bank_open, exp_open, "auto precharge closes row");
      $display("test auto precharge done");
      ctrl.issue(dcr_pkg::DCR_MRS, 3'h3, 14'h0004, 8);
      reg_chk(dcr_pkg::REG_STAT, 32'h0000_0100);
      for (int k = 0; k < 5; k++)
         ctrl.issue(dcr_pkg::DCR_RD, 3'h0, RD_A[k] & 14'h1004,
                    RD_G[k]);
      repeat (12) @(posedge core_clk);
      ctrl.issue(dcr_pkg::DCR_MRS, 3'h3, 14'h0005, 8);
      ctrl.issue(dcr_pkg::DCR_RD, 3'h0, 14'h1000, 16);
      ctrl.issue(dcr_pkg::DCR_MRS, 3'h3, 14'h0000, 8);
      reg_chk(dcr_pkg::REG_STAT, 32'h0000_0000);
      ctrl.issue(dcr_pkg::DCR_ACT, 3'h0, 14'h0001, 4);
      ctrl.issue(dcr_pkg::DCR_RD, 3'h0, 14'h1000, 20);
      $display("test calibration pattern done");
      close_out();
   end
endmodule
